// ==== core/law_watchdog.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "law_defines.svh"

// Behaviour
// RL1: each counter compares its running count with a default or written expiration value.
// RL2: latching counter is enabled by writing its enable bit.
// RL3: enabled latching counter leaves enable only through initialize or its attention.
// RL4: every qualifying tick or event moves an enabled count toward expiry.
// RL5: enabled latching counter raises attention on reaching expiry.
// RL6: no attention is raised by a disabled counter.
// RL7: both counters obey a dedicated initialize input apart from the register port.
// RL8: after initialize or attention, enable, count and expiry take fixed readable values.
// RL9: enabled latching counter ignores expiry writes and deferrals.
// RL10: deferral policy value is configurable.
// RL11: reconfiguration policy value is configurable.
// RL12: only accepted verdicts with a fresh nonce take effect.
// RL13: policies change only with authorization while enabled or reconfig policy set.
// RL14: with reconfig policy set, disable, expiry and policy changes need authorization.
// RL15: authorized counter is enabled by writing its enable bit.
// RL16: enabled authorized counter raises attention on reaching expiry.
// RL17: enabled authorized counter defers only on authorized defer or initialize.
// RL18: enabled authorized counter reconfigures only on authorized request or initialize.
// RL19: enabled authorized counter disables only by authorization, initialize or attention.
// RL20: each accepted deferral pushes expiry further out, repeatably.
// RL21: a nonce is usable once, so collected tickets cannot be replayed.
// RL22: deferral increases remaining count before expiry.
// RL23: checker delivers one-cycle verdict strobes with a request kind.
// RL24: attention is a registered level held until initialize.
module law_watchdog
   import law_pkg::*;
#(
   parameter bit USE_EVENTS = 1'b0
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        init_pulse,
   input  wire logic        event_in,
   input  wire law_bus_t    bus,
   input  wire law_auth_t   auth,
   output logic [31:0]      rdata,
   output logic             latch_attn,
   output logic             auth_attn
);

   logic        clear;
   logic        tick;
   logic        lat_en_q;
   logic [31:0] lat_exp_q;
   logic [31:0] lat_cnt;
   logic        lat_hit;
   logic        adw_en_q;
   logic [31:0] adw_exp_q;
   logic [31:0] adw_cnt;
   logic        adw_hit;
   logic [31:0] dpol_q;
   logic [31:0] rpol_q;
   logic [31:0] nonce_q;
   logic        refused_q;
   logic        wr_ctrl;
   logic        wr_exp;
   logic        wr_dpol;
   logic        wr_rpol;
   logic        ok_auth;
   logic        rpol_set;
   logic        adw_locked;
   logic        adw_defer;

   // initialize comes from its own protected pin, never from the register port
   assign clear    = !rst_b || init_pulse; // RL7

   assign wr_ctrl  = bus.wr && bus.addr == `LAW_REG_CTRL;
   assign wr_exp   = bus.wr && bus.addr == `LAW_REG_EXPIRY;
   assign wr_dpol  = bus.wr && bus.addr == `LAW_REG_DPOLICY;
   assign wr_rpol  = bus.wr && bus.addr == `LAW_REG_RPOLICY;

   // a verdict counts only once per nonce; a stale nonce is a replay
   assign ok_auth    = auth.valid && auth.accepted && auth.nonce == nonce_q; // RL12 RL21 RL23
   assign rpol_set   = rpol_q != `LAW_POLICY_RST;
   assign adw_locked = adw_en_q || rpol_set; // RL13 RL14
   assign adw_defer  = adw_en_q && ok_auth && auth.kind == LAW_REQ_DEFER; // RL17 RL20 RL22

   law_tick_sel #(
      .USE_EVENTS (USE_EVENTS)
   ) u_tick (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .event_in (event_in),
      .tick     (tick)
   );

   law_counter #(
      .WIDTH (32)
   ) u_lat_cnt (
      .core_clk   (core_clk),
      .clear      (clear || latch_attn),
      .enabled    (lat_en_q),
      .tick       (tick),
      .defer      (1'b0),
      .defer_step ('0),
      .expiry     (lat_exp_q),
      .count      (lat_cnt),
      .hit        (lat_hit)
   );

   law_counter #(
      .WIDTH (32)
   ) u_adw_cnt (
      .core_clk   (core_clk),
      .clear      (clear || auth_attn),
      .enabled    (adw_en_q),
      .tick       (tick),
      .defer      (adw_defer),
      .defer_step (`LAW_DEFER_STEP),
      .expiry     (adw_exp_q),
      .count      (adw_cnt),
      .hit        (adw_hit)
   );

   // latching counter enable and expiry
   always_ff @(posedge core_clk) begin
      if (clear) begin
         lat_en_q  <= 1'b0; // RL8
         lat_exp_q <= `LAW_EXPIRY_RST; // RL1
      end else if (latch_attn) begin
         lat_en_q  <= 1'b0; // RL3 RL8
         lat_exp_q <= `LAW_EXPIRY_RST;
      end else if (!lat_en_q) begin // RL9
         if (wr_ctrl && bus.wdata[`LAW_CTRL_LATCH_EN]) begin
            lat_en_q <= 1'b1; // RL2
         end
         if (wr_exp) begin
            lat_exp_q <= bus.wdata; // RL1
         end
      end
      // enabled: writes ignored entirely
   end

   // attention levels held until initialize
   always_ff @(posedge core_clk) begin
      if (clear) begin
         latch_attn <= 1'b0;
         auth_attn  <= 1'b0;
      end else begin
         if (lat_hit && lat_en_q) begin
            latch_attn <= 1'b1; // RL5 RL6 RL24
         end
         if (adw_hit && adw_en_q) begin
            auth_attn <= 1'b1; // RL16 RL6 RL24
         end
      end
   end

   // authorized counter enable and expiry
   always_ff @(posedge core_clk) begin
      if (clear || auth_attn) begin
         adw_en_q  <= 1'b0; // RL8 RL19
         adw_exp_q <= `LAW_EXPIRY_RST;
      end else begin
         if (wr_ctrl && bus.wdata[`LAW_CTRL_AUTH_EN]) begin
            adw_en_q <= 1'b1; // RL15
         end else if (ok_auth && auth.kind == LAW_REQ_DISABLE) begin
            adw_en_q <= 1'b0; // RL19
         end else if (wr_ctrl && !adw_locked) begin
            adw_en_q <= 1'b0;
         end
         if (ok_auth && auth.kind == LAW_REQ_RECONF) begin
            adw_exp_q <= auth.value; // RL18
         end else if (wr_exp && !adw_locked) begin
            adw_exp_q <= bus.wdata; // RL14
         end
      end
   end

   // policies
   always_ff @(posedge core_clk) begin
      if (clear) begin
         dpol_q <= `LAW_POLICY_RST;
         rpol_q <= `LAW_POLICY_RST;
      end else if (ok_auth && auth.kind == LAW_REQ_POLICY) begin
         if (auth.which_rpol) begin
            rpol_q <= auth.value; // RL11 RL13
         end else begin
            dpol_q <= auth.value; // RL10 RL13
         end
      end else if (!adw_locked) begin
         if (wr_dpol) begin
            dpol_q <= bus.wdata; // RL10
         end
         if (wr_rpol) begin
            rpol_q <= bus.wdata; // RL11
         end
      end
   end

   // nonce advances on every accepted fresh-nonce verdict so nothing can be held back and replayed
   always_ff @(posedge core_clk) begin
      if (clear) begin
         nonce_q <= `LAW_NONCE_RST;
      end else if (ok_auth) begin
         nonce_q <= nonce_q + 32'h0000_0001; // RL21
      end
   end

   // sticky refusal flag, cleared by a status read; the new refusal wins
   always_ff @(posedge core_clk) begin
      if (clear) begin
         refused_q <= 1'b0;
      end else if (auth.valid && !ok_auth) begin
         refused_q <= 1'b1; // RL12
      end else if (bus.rd && bus.addr == `LAW_REG_STATUS) begin
         refused_q <= 1'b0;
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rdata <= '0;
      end else if (bus.rd) begin
         case (bus.addr)
            `LAW_REG_CTRL:    rdata <= {30'h0, adw_en_q, lat_en_q};
            `LAW_REG_EXPIRY:  rdata <= lat_exp_q;
            `LAW_REG_COUNT:   rdata <= lat_cnt;
            `LAW_REG_STATUS:  rdata <= {26'h0, refused_q, rpol_set, auth_attn,
                                        adw_en_q, latch_attn, lat_en_q};
            `LAW_REG_DPOLICY: rdata <= dpol_q;
            `LAW_REG_RPOLICY: rdata <= rpol_q;
            `LAW_REG_ACTIVE:  rdata <= adw_cnt;
            `LAW_REG_NONCE:   rdata <= nonce_q;
            default:          rdata <= adw_exp_q;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   chk_latch_locked: assert property (@(posedge core_clk) disable iff (!rst_b) // RL3
      lat_en_q && !init_pulse && !latch_attn |=> lat_en_q)
      else $error("latching counter left enable without cause");

   chk_latch_exp_fixed: assert property (@(posedge core_clk) disable iff (!rst_b) // RL9
      lat_en_q && !init_pulse && !latch_attn |=> $stable(lat_exp_q))
      else $error("latching expiry changed while enabled");

   chk_latch_attn: assert property (@(posedge core_clk) disable iff (!rst_b || init_pulse) // RL5
      lat_en_q && lat_hit |=> latch_attn)
      else $error("latching attention missing at expiry");

   chk_attn_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // RL24
      latch_attn && !init_pulse |=> latch_attn)
      else $error("attention dropped before initialize");

   chk_init_clears: assert property (@(posedge core_clk) disable iff (!rst_b) // RL8
      init_pulse |=> !lat_en_q && !adw_en_q && lat_cnt == 32'h0 && !latch_attn)
      else $error("initialize did not restore defaults");

   chk_count_step: assert property (@(posedge core_clk) disable iff (!rst_b) // RL4
      lat_en_q && tick && !lat_hit && !init_pulse && !latch_attn |=> lat_cnt == $past(lat_cnt) + 32'h1)
      else $error("count did not advance");

   chk_adw_disable: assert property (@(posedge core_clk) disable iff (!rst_b) // RL19
      adw_en_q && !init_pulse && !auth_attn && !(ok_auth && auth.kind == LAW_REQ_DISABLE) |=> adw_en_q)
      else $error("authorized counter disabled without authorization");

   chk_policy_guard: assert property (@(posedge core_clk) disable iff (!rst_b) // RL13
      adw_locked && !ok_auth && !init_pulse |=> $stable(rpol_q) && $stable(dpol_q))
      else $error("policy changed without authorization");

   chk_no_attn_off: assert property (@(posedge core_clk) disable iff (!rst_b) // RL6
      !adw_en_q && !auth_attn && !init_pulse |=> !auth_attn)
      else $error("disabled counter raised attention");

   // expiry walk: hit, then attention, then enable, count and expiry back to defaults
   sequence s_lat_expire;
      lat_en_q && lat_hit && !latch_attn;
   endsequence

   sequence s_lat_cleanup;
      latch_attn && !lat_en_q && lat_cnt == 32'h0 && lat_exp_q == `LAW_EXPIRY_RST;
   endsequence

   sequence s_adw_expire;
      adw_en_q && adw_hit && !auth_attn;
   endsequence

   sequence s_adw_cleanup;
      auth_attn && !adw_en_q && adw_cnt == 32'h0 && adw_exp_q == `LAW_EXPIRY_RST;
   endsequence

   chk_latch_after_attn: assert property (@(posedge core_clk) disable iff (!rst_b || init_pulse) // RL8
      s_lat_expire |=> latch_attn ##1 s_lat_cleanup)
      else $error("latching counter state wrong after attention");

   chk_auth_after_attn: assert property (@(posedge core_clk) disable iff (!rst_b || init_pulse) // RL16
      s_adw_expire |=> auth_attn ##1 s_adw_cleanup)
      else $error("authorized counter state wrong after attention");

   chk_latch_no_attn: assert property (@(posedge core_clk) disable iff (!rst_b) // RL6
      !lat_en_q && !latch_attn && !init_pulse |=> !latch_attn)
      else $error("disabled latching counter raised attention");

   chk_auth_hold: assert property (@(posedge core_clk) disable iff (!rst_b) // RL24
      auth_attn && !init_pulse |=> auth_attn)
      else $error("authorized attention dropped before initialize");

   chk_adw_exp_guard: assert property (@(posedge core_clk) disable iff (!rst_b) // RL14
      adw_locked && !init_pulse && !auth_attn && !(ok_auth && auth.kind == LAW_REQ_RECONF)
      |=> $stable(adw_exp_q))
      else $error("authorized expiry changed without authorization");

   chk_defer_pull: assert property (@(posedge core_clk) disable iff (!rst_b) // RL20
      adw_en_q && ok_auth && auth.kind == LAW_REQ_DEFER && !init_pulse && !auth_attn
      |=> adw_cnt < $past(adw_cnt) || adw_cnt == 32'h0)
      else $error("accepted deferral did not add remaining time");

   chk_no_free_defer: assert property (@(posedge core_clk) disable iff (!rst_b) // RL17
      adw_en_q && !adw_defer && !init_pulse && !auth_attn |=> adw_cnt >= $past(adw_cnt))
      else $error("authorized count pulled back without deferral");

   chk_nonce_step: assert property (@(posedge core_clk) disable iff (!rst_b) // RL21
      ok_auth && !init_pulse |=> nonce_q == $past(nonce_q) + 32'h1)
      else $error("nonce not consumed by accepted verdict");

   chk_refuse_flag: assert property (@(posedge core_clk) disable iff (!rst_b) // RL12
      auth.valid && !ok_auth && !init_pulse |=> refused_q)
      else $error("refused verdict not flagged");

   chk_latch_enable: assert property (@(posedge core_clk) disable iff (!rst_b) // RL2
      !lat_en_q && !latch_attn && !clear && wr_ctrl && bus.wdata[`LAW_CTRL_LATCH_EN] |=> lat_en_q)
      else $error("latching counter did not enable");

   chk_auth_enable: assert property (@(posedge core_clk) disable iff (!rst_b) // RL15
      !adw_en_q && !auth_attn && !clear && wr_ctrl && bus.wdata[`LAW_CTRL_AUTH_EN] |=> adw_en_q)
      else $error("authorized counter did not enable");

   chk_lat_idle_count: assert property (@(posedge core_clk) disable iff (!rst_b) // RL4
      !lat_en_q && !latch_attn && !init_pulse |=> $stable(lat_cnt))
      else $error("disabled latching counter moved");

endmodule

`default_nettype wire

// ==== inc/law_defines.svh ====
`ifndef LAW_DEFINES_SVH
`define LAW_DEFINES_SVH

// register indices on the plain register port
`define LAW_REG_CTRL      4'h0
`define LAW_REG_EXPIRY    4'h1
`define LAW_REG_COUNT     4'h2
`define LAW_REG_STATUS    4'h3
`define LAW_REG_DPOLICY   4'h4
`define LAW_REG_RPOLICY   4'h5
`define LAW_REG_ACTIVE    4'h6
`define LAW_REG_NONCE     4'h7

// control register fields
`define LAW_CTRL_LATCH_EN 0
`define LAW_CTRL_AUTH_EN  1

// status register fields
`define LAW_ST_LATCH_EN   0
`define LAW_ST_LATCH_ATN  1
`define LAW_ST_AUTH_EN    2
`define LAW_ST_AUTH_ATN   3
`define LAW_ST_RPOL_SET   4
`define LAW_ST_REFUSED    5

// reset and post-attention values, and the deferral step
`define LAW_EXPIRY_RST    32'h0000_ffff
`define LAW_COUNT_RST     32'h0000_0000
`define LAW_POLICY_RST    32'h0000_0000
`define LAW_DEFER_STEP    32'h0000_ffff
`define LAW_NONCE_RST     32'h0000_0001

`endif

// ==== inc/law_pkg.sv ====
package law_pkg;

   typedef enum logic [1:0] {
      LAW_REQ_DEFER,
      LAW_REQ_RECONF,
      LAW_REQ_DISABLE,
      LAW_REQ_POLICY
   } law_req_t;

   // verdict from the external authorization checker
   typedef struct packed {
      logic        valid;
      logic        accepted;
      law_req_t    kind;
      logic [31:0] nonce;
      logic [31:0] value;
      logic        which_rpol;
   } law_auth_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } law_bus_t;

endpackage

// ==== core/law_tick_sel.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "law_defines.svh"

// picks the counting source: every clock or an event strobe
module law_tick_sel
   import law_pkg::*;
#(
   parameter bit USE_EVENTS = 1'b0
) (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic event_in,
   output logic      tick
);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tick <= 1'b0;
      end else begin
         tick <= USE_EVENTS ? event_in : 1'b1; // RL4
      end
   end

endmodule

`default_nettype wire

// ==== core/law_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "law_defines.svh"

// one up-counter toward an expiration value; reused by both variants
module law_counter
   import law_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             clear,
   input  wire logic             enabled,
   input  wire logic             tick,
   input  wire logic             defer,
   input  wire logic [WIDTH-1:0] defer_step,
   input  wire logic [WIDTH-1:0] expiry,
   output logic      [WIDTH-1:0] count,
   output logic                  hit
);

   always_ff @(posedge core_clk) begin
      if (clear) begin
         count <= '0;
      end else if (enabled && defer) begin
         // deferral pulls the count back, never below zero
         count <= (count > defer_step) ? count - defer_step : '0; // RL20 RL22
      end else if (enabled && tick && count < expiry) begin
         count <= count + 1'b1; // RL4
      end
   end

   // an expiry lowered below the running count counts as reached, so it cannot be skipped
   assign hit = enabled && (count >= expiry); // RL1

endmodule

`default_nettype wire

// ==== bench/law_auth_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// far-side authorization checker: turns a bench request into a one-cycle verdict
module law_auth_model
   import law_pkg::*;
(
   input  wire logic      core_clk,
   input  wire logic      go,
   input  wire law_auth_t req,
   output law_auth_t      auth
);
   // idle fields show the request inverted so a stale verdict never holds a usable nonce
   always @(posedge core_clk) begin
      if (go) begin
         auth <= {1'b1, req[$bits(law_auth_t)-2:0]};
      end else begin
         auth <= {1'b0, ~req[$bits(law_auth_t)-2:0]};
      end
   end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "law_defines.svh"
module tb
   import law_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        init_pulse = 1'b0;
   logic        event_in = 1'b0;
   logic        go = 1'b0;
   law_bus_t    bus = '0;
   law_auth_t   req = '0;
   law_auth_t   auth;
   logic [31:0] rdata;
   logic [31:0] rdata_ev;
   logic [31:0] v;
   logic        latch_attn;
   logic        auth_attn;
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          n;

   always #25 core_clk = ~core_clk;

   law_watchdog dut_u (.core_clk(core_clk), .rst_b(rst_b), .init_pulse(init_pulse), .event_in(event_in),
      .bus(bus), .auth(auth), .rdata(rdata), .latch_attn(latch_attn), .auth_attn(auth_attn));
   law_auth_model partner_u (.core_clk(core_clk), .go(go), .req(req), .auth(auth));
   // second copy counts event strobes instead of clocks
   law_watchdog #(.USE_EVENTS(1'b1)) dut_ev_u (.core_clk(core_clk), .rst_b(rst_b), .init_pulse(init_pulse),
      .event_in(event_in), .bus(bus), .auth(auth), .rdata(rdata_ev), .latch_attn(), .auth_attn());

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge core_clk);
      bus <= '0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge core_clk);
      bus <= '0;
      #1 d = rdata;
   endtask

   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(nm, d, exp);
   endtask

   task automatic verdict(input logic acc, input law_req_t k, input logic [31:0] nc, input logic [31:0] val,
                          input logic rp);
      @(posedge core_clk);
      req <= '{1'b0, acc, k, nc, val, rp};
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic pulse_init();
      @(posedge core_clk);
      init_pulse <= 1'b1;
      @(posedge core_clk);
      init_pulse <= 1'b0;
      @(posedge core_clk);
      #1;
   endtask

   // bounded wait so a missing attention cannot hang the run
   task automatic wait_attn(input bit which, output int c);
      c = 0;
      while ((which ? auth_attn : latch_attn) !== 1'b1 && c < 300) begin
         @(posedge core_clk);
         #1 c++;
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      summarize();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rchk("expiry rst", `LAW_REG_EXPIRY, `LAW_EXPIRY_RST);
      rchk("count rst", `LAW_REG_COUNT, `LAW_COUNT_RST);
      rchk("status rst", `LAW_REG_STATUS, 32'h0);
      rchk("nonce rst", `LAW_REG_NONCE, `LAW_NONCE_RST);
      // latching counter
      wr(`LAW_REG_EXPIRY, 32'h0);
      repeat (5) @(posedge core_clk);
      #1 chk("latch attn disabled", latch_attn, 32'h0);
      wr(`LAW_REG_EXPIRY, 32'h64);
      wr(`LAW_REG_CTRL, 32'h1);
      wr(`LAW_REG_EXPIRY, 32'h5);
      wr(`LAW_REG_CTRL, 32'h0);
      rchk("latch expiry locked", `LAW_REG_EXPIRY, 32'h64);
      rchk("latch enabled", `LAW_REG_STATUS, 32'h1);
      repeat (3) begin
         @(posedge core_clk);
         event_in <= 1'b1;
      end
      @(posedge core_clk);
      event_in <= 1'b0;
      rd(`LAW_REG_COUNT, v);
      chk("event count", rdata_ev, 32'h3);
      chk("latch counting", 32'(v > 32'h8 && v < 32'h64), 32'h1);
      wait_attn(1'b0, n);
      chk("latch attn", latch_attn, 32'h1);
      repeat (10) @(posedge core_clk);
      #1 chk("latch attn held", latch_attn, 32'h1);
      rchk("latch status after", `LAW_REG_STATUS, 32'h2);
      rchk("latch expiry after", `LAW_REG_EXPIRY, `LAW_EXPIRY_RST);
      rchk("latch count after", `LAW_REG_COUNT, 32'h0);
      pulse_init();
      chk("latch attn init", latch_attn, 32'h0);
      // authorized-deferral counter
      wr(`LAW_REG_DPOLICY, 32'h5);
      rchk("dpolicy set", `LAW_REG_DPOLICY, 32'h5);
      wr(`LAW_REG_CTRL, 32'h2);
      wr(`LAW_REG_DPOLICY, 32'h7);
      wr(`LAW_REG_CTRL, 32'h0);
      rchk("dpolicy locked", `LAW_REG_DPOLICY, 32'h5);
      rchk("auth still on", `LAW_REG_STATUS, 32'h4);
      repeat (30) @(posedge core_clk);
      rd(`LAW_REG_ACTIVE, v);
      chk("auth counting", 32'(v > 32'h14), 32'h1);
      verdict(1'b1, LAW_REQ_DEFER, 32'h9, 32'h0, 1'b0);
      rchk("bad nonce refused", `LAW_REG_STATUS, 32'h24);
      verdict(1'b0, LAW_REQ_DEFER, 32'h1, 32'h0, 1'b0);
      rchk("rejected refused", `LAW_REG_STATUS, 32'h24);
      verdict(1'b1, LAW_REQ_DEFER, 32'h1, 32'h0, 1'b0);
      rd(`LAW_REG_ACTIVE, v);
      chk("deferred", 32'(v < 32'ha), 32'h1);
      rchk("nonce moved", `LAW_REG_NONCE, 32'h2);
      verdict(1'b1, LAW_REQ_DEFER, 32'h1, 32'h0, 1'b0);
      rchk("replay refused", `LAW_REG_STATUS, 32'h24);
      verdict(1'b1, LAW_REQ_POLICY, 32'h2, 32'h3, 1'b1);
      rchk("rpolicy set", `LAW_REG_RPOLICY, 32'h3);
      wr(`LAW_REG_DPOLICY, 32'h9);
      rchk("dpolicy needs auth", `LAW_REG_DPOLICY, 32'h5);
      verdict(1'b1, LAW_REQ_RECONF, 32'h3, 32'hc8, 1'b0);
      rchk("auth expiry reconf", 4'h8, 32'hc8);
      wait_attn(1'b1, n);
      chk("auth attn", auth_attn, 32'h1);
      rd(`LAW_REG_STATUS, v);
      chk("auth off after attn", {30'h0, v[3:2]}, 32'h2);
      rchk("auth expiry after", 4'h8, `LAW_EXPIRY_RST);
      pulse_init();
      chk("auth attn init", auth_attn, 32'h0);
      rchk("rpolicy init", `LAW_REG_RPOLICY, `LAW_POLICY_RST);
      summarize();
   end
endmodule
`default_nettype wire
